// *** logic/bridge_cmd_pkg.sv ***
// Shared constants and types for the bus command decoder.
package bridge_cmd_pkg;

	// ==========================================================================
	// Clock and timing.
	// ==========================================================================
	localparam int CLK_HZ        = 25000000;
	localparam int CLR_TIME_US   = 100;
	// Least time in whole cycles, with the MHz factor rounded down.
	localparam int CLR_CYCLES    = (CLR_TIME_US * (CLK_HZ / 1000000));
	localparam int CNT_W         = 13;

	// ==========================================================================
	// Drive states of one output.
	// ==========================================================================
	typedef enum logic [2:0] {
		DRV_TRI,
		DRV_SRC,
		DRV_SNK,
		DRV_SRC_140MA,
		DRV_SNK_140MA,
		DRV_SRC_10MA,
		DRV_SNK_10MA
	} drive_e;

	// ==========================================================================
	// Command patterns on the data nibble (bit 3 down to bit 0).
	// ==========================================================================
	localparam logic [3:0] CMD_STANDBY  = 4'h0;
	localparam logic [3:0] CMD_M1_RIGHT = 4'h4;
	localparam logic [3:0] CMD_M1_LEFT  = 4'h3;
	localparam logic [3:0] CMD_M2_RIGHT = 4'h5;
	localparam logic [3:0] CMD_M2_LEFT  = 4'h2;
	localparam logic [3:0] CMD_M3_RIGHT = 4'h6;
	localparam logic [3:0] CMD_M3_LEFT  = 4'h1;
	localparam logic [3:0] CMD_BRAKE    = 4'h7;
	localparam logic [3:0] CMD_HIGHSIDE = 4'h8;
	localparam logic [3:0] CMD_CLEAR    = 4'hf;
	localparam logic [2:0] TST_SRC140   = 3'h2;
	localparam logic [2:0] TST_SNK140   = 3'h1;
	localparam logic [2:0] TST_ALL      = 3'h6;

	// ==========================================================================
	// Fault codes on read bits 1..0.
	// ==========================================================================
	localparam logic [1:0] FLT_NONE   = 2'h0;
	localparam logic [1:0] FLT_BRIDGE = 2'h1;
	localparam logic [1:0] FLT_HIGH   = 2'h2;
	localparam logic [1:0] FLT_OVV    = 2'h3;

	// Reset values.
	localparam logic [3:0] CMD_RESET  = 4'h0;
	localparam logic       MODE_RESET = 1'b0;

endpackage : bridge_cmd_pkg

// *** logic/cmd_decode.sv ***
// Combinational decoder from the live command to five output drive states.
`timescale 1ns/1ps

module cmd_decode (
	// Command.
	input  wire logic                  valid,
	input  wire logic                  mode,
	input  wire logic [3:0]            cmd,
	// Drive states.
	output bridge_cmd_pkg::drive_e     drv1,
	output bridge_cmd_pkg::drive_e     drv2,
	output bridge_cmd_pkg::drive_e     drv3,
	output bridge_cmd_pkg::drive_e     drv4,
	output bridge_cmd_pkg::drive_e     drv5
);

	// ==========================================================================
	// Decode.
	// ==========================================================================
	// Every output defaults to tristate so unlisted patterns are safe.
	always_comb begin
		drv1 = bridge_cmd_pkg::DRV_TRI;
		drv2 = bridge_cmd_pkg::DRV_TRI;
		drv3 = bridge_cmd_pkg::DRV_TRI;
		drv4 = bridge_cmd_pkg::DRV_TRI;
		drv5 = bridge_cmd_pkg::DRV_TRI;
		if (!valid) begin
			drv1 = bridge_cmd_pkg::DRV_TRI;
		end else if (mode) begin
			case (cmd[2:0])
				bridge_cmd_pkg::TST_SRC140: begin
					drv4 = bridge_cmd_pkg::DRV_SRC_140MA;
				end
				bridge_cmd_pkg::TST_SNK140: begin
					drv4 = bridge_cmd_pkg::DRV_SNK_140MA;
				end
				bridge_cmd_pkg::TST_ALL: begin
					drv1 = bridge_cmd_pkg::DRV_SNK_10MA;
					drv2 = bridge_cmd_pkg::DRV_SNK_10MA;
					drv3 = bridge_cmd_pkg::DRV_SNK_10MA;
					drv4 = bridge_cmd_pkg::DRV_SRC_140MA;
					drv5 = bridge_cmd_pkg::DRV_SRC_10MA;
				end
				default: begin
					drv4 = bridge_cmd_pkg::DRV_TRI;
				end
			endcase
		end else begin
			case (cmd)
				bridge_cmd_pkg::CMD_M1_RIGHT: begin
					drv1 = bridge_cmd_pkg::DRV_SRC;
					drv4 = bridge_cmd_pkg::DRV_SNK;
				end
				bridge_cmd_pkg::CMD_M1_LEFT: begin
					drv1 = bridge_cmd_pkg::DRV_SNK;
					drv4 = bridge_cmd_pkg::DRV_SRC;
				end
				bridge_cmd_pkg::CMD_M2_RIGHT: begin
					drv2 = bridge_cmd_pkg::DRV_SRC;
					drv4 = bridge_cmd_pkg::DRV_SNK;
				end
				bridge_cmd_pkg::CMD_M2_LEFT: begin
					drv2 = bridge_cmd_pkg::DRV_SNK;
					drv4 = bridge_cmd_pkg::DRV_SRC;
				end
				bridge_cmd_pkg::CMD_M3_RIGHT: begin
					drv3 = bridge_cmd_pkg::DRV_SRC;
					drv4 = bridge_cmd_pkg::DRV_SNK;
				end
				bridge_cmd_pkg::CMD_M3_LEFT: begin
					drv3 = bridge_cmd_pkg::DRV_SNK;
					drv4 = bridge_cmd_pkg::DRV_SRC;
				end
				bridge_cmd_pkg::CMD_BRAKE: begin
					drv1 = bridge_cmd_pkg::DRV_SNK;
					drv2 = bridge_cmd_pkg::DRV_SNK;
					drv3 = bridge_cmd_pkg::DRV_SNK;
					drv4 = bridge_cmd_pkg::DRV_SNK;
				end
				bridge_cmd_pkg::CMD_HIGHSIDE: begin
					drv5 = bridge_cmd_pkg::DRV_SRC;
				end
				default: begin
					drv5 = bridge_cmd_pkg::DRV_TRI;
				end
			endcase
		end
	end

endmodule // cmd_decode

// *** logic/bus_cmd_bridge.sv ***
// Parallel bus command interpreter for a quad half-bridge power interface.
// Function
// - Nibble bus with three control inputs.
// - Deselected: hold outputs, ignore inputs.
// - Mode-low all zeros: tristate, standby.
// - Mode-low motor patterns drive bridge pairs.
// - 0111 brakes all bridges; 1000 sources high side.
// - Mode-high load test current patterns.
// - Mode-low 1111 clears and tristates all.
// - Select low too long: clear, standby.
// - Write while selected acts immediately.
// - Deselect stores and keeps last command.
// - Read mode drives nibble; master releases.
// - Mode-low read returns bridge levels.
// - Level bit high above 0.6, low below 0.4.
// - Mode-high read returns fault code, flags.
// - Logic supply up resets internal logic.
// - Select low too long after power: standby.
// - Select rising with supply: standby.
// - Select low at power-up: ignore bus.
// - Deselected inputs disabled for bus sharing.
// - Overcurrent flags latch until next write.
// - Falling select wakes from standby.
`timescale 1ns/1ps

module bus_cmd_bridge #(
	parameter int CLR_CYCLES = bridge_cmd_pkg::CLR_CYCLES
) (
	// Clock and reset.
	input  wire logic                  MCLK,
	input  wire logic                  RESET_N,
	// Bus control.
	input  wire logic                  CHIP_SELECT_ACTIVE_LOW,
	input  wire logic                  READ_NOT_WRITE_SELECT,
	input  wire logic                  MODE_SELECT,
	// Bus data nibble, split into three signals.
	input  wire logic [3:0]            BUS_DATA_NIBBLE_IN,
	output logic      [3:0]            BUS_DATA_NIBBLE_OUT,
	output logic      [3:0]            BUS_DATA_NIBBLE_OE_N,
	// Analog sense inputs.
	input  wire logic [4:0]            OUT_LEVEL_HIGH,
	input  wire logic [4:0]            OUT_LEVEL_LOW,
	input  wire logic                  BRIDGE_OVERCURRENT_DET,
	input  wire logic                  HIGH_SIDE_OVERCURRENT_DET,
	input  wire logic                  OVERVOLTAGE_FLAG,
	input  wire logic                  OVERTEMPERATURE_FLAG,
	// Output drive states.
	output bridge_cmd_pkg::drive_e     BRIDGE1,
	output bridge_cmd_pkg::drive_e     BRIDGE2,
	output bridge_cmd_pkg::drive_e     BRIDGE3,
	output bridge_cmd_pkg::drive_e     BRIDGE4,
	output bridge_cmd_pkg::drive_e     HIGH_SIDE_OUTPUT,
	// Status.
	output logic                       STANDBY,
	output logic                       BRIDGE_OVERCURRENT_FLAG,
	output logic                       HIGH_SIDE_OVERCURRENT_FLAG
);

	// ==========================================================================
	// State.
	// ==========================================================================
	typedef struct packed {
		logic                                  cs_d;
		logic                                  armed;
		logic                                  standby;
		logic                                  valid;
		logic                                  mode;
		logic [3:0]                            cmd;
		logic [bridge_cmd_pkg::CNT_W-1:0]      cnt;
		logic                                  expired;
		logic [4:0]                            level;
		logic                                  ovc_bridge;
		logic                                  ovc_high;
		logic [3:0]                            dout;
		logic [3:0]                            oe_n;
	} state_s;

	state_s state_reg;
	state_s state_next;

	logic                                  cs_low;
	logic                                  fall;
	logic                                  writing;
	logic                                  reading;
	logic                                  live_valid;
	logic                                  live_mode;
	logic [3:0]                            live_cmd;
	logic [3:0]                            rd_word;
	logic [bridge_cmd_pkg::CNT_W-1:0]      cnt_limit;

	assign cnt_limit = bridge_cmd_pkg::CNT_W'(CLR_CYCLES);

	// ==========================================================================
	// Bus qualifiers.
	// ==========================================================================
	// Nothing on the bus is looked at unless select is low and either just fell or is armed.
	assign cs_low  = !CHIP_SELECT_ACTIVE_LOW;
	assign fall    = cs_low && state_reg.cs_d;
	// A falling edge wakes the bus even after a timeout, so it counts on
	// its own; otherwise select must be armed and not yet expired.
	assign writing = cs_low && !READ_NOT_WRITE_SELECT &&
		(fall || (state_reg.armed && !state_reg.expired));
	assign reading = cs_low && READ_NOT_WRITE_SELECT &&
		(fall || (state_reg.armed && !state_reg.expired));

	// ==========================================================================
	// Live command view.
	// ==========================================================================
	// Transparent writes show the nibble at once rather than a cycle later.
	always_comb begin
		live_valid = state_reg.valid;
		live_mode  = state_reg.mode;
		live_cmd   = state_reg.cmd;
		if (writing) begin
			live_mode = MODE_SELECT;
			live_cmd  = BUS_DATA_NIBBLE_IN;
			live_valid = MODE_SELECT ||
				((BUS_DATA_NIBBLE_IN != bridge_cmd_pkg::CMD_STANDBY) &&
				(BUS_DATA_NIBBLE_IN != bridge_cmd_pkg::CMD_CLEAR));
		end
	end

	// ==========================================================================
	// Read word.
	// ==========================================================================
	always_comb begin
		rd_word = 4'h0;
		if (MODE_SELECT) begin
			if (OVERVOLTAGE_FLAG) begin
				rd_word[1:0] = bridge_cmd_pkg::FLT_OVV;
			end else if (state_reg.ovc_bridge) begin
				rd_word[1:0] = bridge_cmd_pkg::FLT_BRIDGE;
			end else if (state_reg.ovc_high) begin
				rd_word[1:0] = bridge_cmd_pkg::FLT_HIGH;
			end else begin
				rd_word[1:0] = bridge_cmd_pkg::FLT_NONE;
			end
			rd_word[2] = OVERTEMPERATURE_FLAG;
			rd_word[3] = state_reg.level[4];
		end else begin
			rd_word = state_reg.level[3:0];
		end
	end

	// ==========================================================================
	// Next state.
	// ==========================================================================
	always_comb begin
		state_next      = state_reg;
		state_next.cs_d = CHIP_SELECT_ACTIVE_LOW;
		// Hysteresis: a level bit only moves on a clear threshold crossing.
		for (int i = 0; i < 5; i++) begin
			if (OUT_LEVEL_HIGH[i]) begin
				state_next.level[i] = 1'b1;
			end else if (OUT_LEVEL_LOW[i]) begin
				state_next.level[i] = 1'b0;
			end
		end
		// Timer restarts on each falling select edge.
		if (fall) begin
			state_next.cnt     = '0;
			state_next.expired = 1'b0;
			state_next.armed   = 1'b1;
		end else if (cs_low && !state_reg.expired) begin
			if (state_reg.cnt >= cnt_limit - 1'b1) begin
				state_next.expired = 1'b1;
			end else begin
				state_next.cnt = state_reg.cnt + 1'b1;
			end
		end
		if (writing) begin
			state_next.valid   = live_valid;
			state_next.mode    = live_mode;
			state_next.cmd     = live_cmd;
			state_next.standby = !live_valid;
			// New write clears old faults; a live fault still sets.
			state_next.ovc_bridge = 1'b0;
			state_next.ovc_high   = 1'b0;
		end else if (fall) begin
			state_next.standby = 1'b0;
		end
		if (BRIDGE_OVERCURRENT_DET) begin
			state_next.ovc_bridge = 1'b1;
		end
		if (HIGH_SIDE_OVERCURRENT_DET) begin
			state_next.ovc_high = 1'b1;
		end
		// Static select low beyond the limit forces clear and standby.
		// A fresh falling edge restarts the count, so it must not clear.
		if (cs_low && state_reg.expired && !fall) begin
			state_next.valid   = 1'b0;
			state_next.standby = 1'b1;
			state_next.cmd     = bridge_cmd_pkg::CMD_RESET;
			state_next.armed   = 1'b0;
		end
		// Rising select keeps the last command for execution.
		if (!cs_low) begin
			state_next.armed = state_reg.armed && !state_reg.expired;
		end
		if (reading) begin
			state_next.dout = rd_word;
			state_next.oe_n = 4'h0;
		end else begin
			state_next.dout = 4'h0;
			state_next.oe_n = 4'hf;
		end
	end

	// ==========================================================================
	// Registers.
	// ==========================================================================
	// Supply-up reset tristates everything and waits for a select edge.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg            <= '0;
			state_reg.cs_d       <= 1'b0;
			state_reg.standby    <= 1'b1;
			state_reg.mode       <= bridge_cmd_pkg::MODE_RESET;
			state_reg.cmd        <= bridge_cmd_pkg::CMD_RESET;
			state_reg.oe_n       <= 4'hf;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Drive decode.
	// ==========================================================================
	cmd_decode u_decode (
		.valid (live_valid),
		.mode  (live_mode),
		.cmd   (live_cmd),
		.drv1  (BRIDGE1),
		.drv2  (BRIDGE2),
		.drv3  (BRIDGE3),
		.drv4  (BRIDGE4),
		.drv5  (HIGH_SIDE_OUTPUT)
	);

	// ==========================================================================
	// Outputs.
	// ==========================================================================
	assign BUS_DATA_NIBBLE_OUT        = state_reg.dout;
	assign BUS_DATA_NIBBLE_OE_N       = state_reg.oe_n;
	assign STANDBY                    = state_reg.standby;
	assign BRIDGE_OVERCURRENT_FLAG    = state_reg.ovc_bridge;
	assign HIGH_SIDE_OVERCURRENT_FLAG = state_reg.ovc_high;

endmodule // bus_cmd_bridge

// *** dv/bus_cmd_bridge_chk.sv ***
// Port-level assertions for the bus command decoder.
`timescale 1ns/1ps

module bus_cmd_bridge_chk #(
	parameter int CLR_CYCLES = 2500
) (
	// Clock and reset.
	input wire logic			MCLK,
	input wire logic			RESET_N,
	// Bus.
	input wire logic			CHIP_SELECT_ACTIVE_LOW,
	input wire logic			READ_NOT_WRITE_SELECT,
	input wire logic			MODE_SELECT,
	input wire logic [3:0]		BUS_DATA_NIBBLE_IN,
	input wire logic [3:0]		BUS_DATA_NIBBLE_OUT,
	input wire logic [3:0]		BUS_DATA_NIBBLE_OE_N,
	// Sense.
	input wire logic [4:0]		OUT_LEVEL_HIGH,
	input wire logic [4:0]		OUT_LEVEL_LOW,
	input wire logic			BRIDGE_OVERCURRENT_DET,
	input wire logic			HIGH_SIDE_OVERCURRENT_DET,
	input wire logic			OVERVOLTAGE_FLAG,
	input wire logic			OVERTEMPERATURE_FLAG,
	// Drives and status.
	input wire bridge_cmd_pkg::drive_e	BRIDGE1,
	input wire bridge_cmd_pkg::drive_e	BRIDGE2,
	input wire bridge_cmd_pkg::drive_e	BRIDGE3,
	input wire bridge_cmd_pkg::drive_e	BRIDGE4,
	input wire bridge_cmd_pkg::drive_e	HIGH_SIDE_OUTPUT,
	input wire logic			STANDBY,
	input wire logic			BRIDGE_OVERCURRENT_FLAG,
	input wire logic			HIGH_SIDE_OVERCURRENT_FLAG
);
	// =====
	// Helper logic.
	// Select-low run length; it saturates so a stuck select cannot wrap.
	int low_cnt_reg;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N)
			low_cnt_reg <= 0;
		else if (CHIP_SELECT_ACTIVE_LOW)
			low_cnt_reg <= 0;
		else if (low_cnt_reg < CLR_CYCLES + 8)
			low_cnt_reg <= low_cnt_reg + 1;
	end

	// Bus cycle kinds; fresh keeps margin from the clear so no race fires.
	wire logic wr = !CHIP_SELECT_ACTIVE_LOW && !READ_NOT_WRITE_SELECT;
	wire logic rd = !CHIP_SELECT_ACTIVE_LOW && READ_NOT_WRITE_SELECT;
	wire logic fresh = !STANDBY && low_cnt_reg < CLR_CYCLES - 2;
	wire logic m0 = wr && fresh && !MODE_SELECT;
	wire logic [14:0] drv = {BRIDGE1, BRIDGE2, BRIDGE3, BRIDGE4,
		HIGH_SIDE_OUTPUT};
	wire logic all_tri = drv == {5{bridge_cmd_pkg::DRV_TRI}};

	// =====
	// Assertions.
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	property p_hold;
		CHIP_SELECT_ACTIVE_LOW && $past(CHIP_SELECT_ACTIVE_LOW)
			&& $past(CHIP_SELECT_ACTIVE_LOW, 2) |-> $stable(drv);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Drive changed while deselected.");
	property p_bus_free;
		CHIP_SELECT_ACTIVE_LOW |=> BUS_DATA_NIBBLE_OE_N == 4'hf;
	endproperty
	a_bus_free: assert property (p_bus_free)
		else $error("Nibble driven while deselected.");
	property p_read_drive;
		rd && fresh |=> BUS_DATA_NIBBLE_OE_N == 4'h0;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("Nibble not driven in read.");
	property p_fault_read;
		rd && fresh && MODE_SELECT |=> BUS_DATA_NIBBLE_OUT[2] ==
			$past(OVERTEMPERATURE_FLAG) && (!$past(OVERVOLTAGE_FLAG)
			|| BUS_DATA_NIBBLE_OUT[1:0] == bridge_cmd_pkg::FLT_OVV);
	endproperty
	a_fault_read: assert property (p_fault_read)
		else $error("Fault read wrong.");
	property p_standby;
		wr && !MODE_SELECT && BUS_DATA_NIBBLE_IN ==
			bridge_cmd_pkg::CMD_STANDBY |-> all_tri ##1 STANDBY;
	endproperty
	a_standby: assert property (p_standby)
		else $error("Standby write not obeyed.");
	property p_clear;
		wr && !MODE_SELECT && BUS_DATA_NIBBLE_IN ==
			bridge_cmd_pkg::CMD_CLEAR |-> all_tri;
	endproperty
	a_clear: assert property (p_clear)
		else $error("Clear write left a drive on.");
	property p_motor;
		m0 && BUS_DATA_NIBBLE_IN == bridge_cmd_pkg::CMD_M1_RIGHT |->
			BRIDGE1 == bridge_cmd_pkg::DRV_SRC && BRIDGE2 ==
			bridge_cmd_pkg::DRV_TRI && BRIDGE4 == bridge_cmd_pkg::DRV_SNK;
	endproperty
	a_motor: assert property (p_motor)
		else $error("Motor write not applied at once.");
	property p_brake;
		m0 && BUS_DATA_NIBBLE_IN == bridge_cmd_pkg::CMD_BRAKE |->
			BRIDGE2 == bridge_cmd_pkg::DRV_SNK
			&& HIGH_SIDE_OUTPUT == bridge_cmd_pkg::DRV_TRI;
	endproperty
	a_brake: assert property (p_brake)
		else $error("Brake write wrong.");
	property p_test;
		wr && fresh && MODE_SELECT && BUS_DATA_NIBBLE_IN[2:0] ==
			bridge_cmd_pkg::TST_ALL |-> BRIDGE3 ==
			bridge_cmd_pkg::DRV_SNK_10MA && BRIDGE4 ==
			bridge_cmd_pkg::DRV_SRC_140MA && HIGH_SIDE_OUTPUT ==
			bridge_cmd_pkg::DRV_SRC_10MA;
	endproperty
	a_test: assert property (p_test)
		else $error("Load test write wrong.");
	property p_timeout;
		low_cnt_reg > CLR_CYCLES + 2 |-> all_tri && STANDBY;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("Long select did not clear.");
	property p_ovc_hold;
		BRIDGE_OVERCURRENT_FLAG && !wr |=> BRIDGE_OVERCURRENT_FLAG;
	endproperty
	a_ovc_hold: assert property (p_ovc_hold)
		else $error("Overcurrent flag dropped without write.");
endmodule // bus_cmd_bridge_chk

// *** dv/bus_master_model.sv ***
// Microcontroller bus master model for the command decoder.
`timescale 1ns/1ps

module bus_master_model (
	// Clock.
	input wire logic		MCLK,
	// Control lines.
	output logic			CHIP_SELECT_ACTIVE_LOW,
	output logic			READ_NOT_WRITE_SELECT,
	output logic			MODE_SELECT,
	// Data wire as the device sees it, and the device's drive.
	output logic [3:0]		BUS_DATA_NIBBLE_IN,
	input wire logic [3:0]	BUS_DATA_NIBBLE_OUT,
	input wire logic [3:0]	BUS_DATA_NIBBLE_OE_N
);
	logic [3:0]	nib_reg = 4'h0;
	logic		rel_reg = 1'h0;

	// Start deselected so the first select is a falling edge.
	initial begin
		CHIP_SELECT_ACTIVE_LOW = 1'h1;
		READ_NOT_WRITE_SELECT = 1'h0;
		MODE_SELECT = 1'h0;
	end

	// Wire level; a released wire has no pull, so it shows the inverse.
	always_comb begin
		BUS_DATA_NIBBLE_IN = (~BUS_DATA_NIBBLE_OE_N & BUS_DATA_NIBBLE_OUT)
			| (BUS_DATA_NIBBLE_OE_N & (rel_reg ? ~nib_reg : nib_reg));
	end

	// One bus step, changed at the falling edge; reads release the data.
	task automatic put(logic c, logic r, logic m, logic [3:0] d);
		@(negedge MCLK);
		CHIP_SELECT_ACTIVE_LOW <= c;
		READ_NOT_WRITE_SELECT <= r;
		MODE_SELECT <= m;
		nib_reg <= d;
		rel_reg <= r;
	endtask
endmodule // bus_master_model

// *** dv/parallel_bus_bridge_command_decoder_test.sv ***
// Self-checking bench for the bus command decoder.
`timescale 1ns/1ps

module parallel_bus_bridge_command_decoder_test;
	// =====
	// Shortened clear time and drive codes.
	localparam int CLR = 24;
	localparam logic [2:0] T = bridge_cmd_pkg::DRV_TRI;
	localparam logic [2:0] S = bridge_cmd_pkg::DRV_SRC;
	localparam logic [2:0] K = bridge_cmd_pkg::DRV_SNK;
	localparam logic [2:0] S4 = bridge_cmd_pkg::DRV_SRC_140MA;
	localparam logic [2:0] K4 = bridge_cmd_pkg::DRV_SNK_140MA;
	localparam logic [2:0] S1 = bridge_cmd_pkg::DRV_SRC_10MA;
	localparam logic [2:0] K1 = bridge_cmd_pkg::DRV_SNK_10MA;
	logic MCLK, RESET_N, CHIP_SELECT_ACTIVE_LOW, READ_NOT_WRITE_SELECT;
	logic MODE_SELECT, OVERVOLTAGE_FLAG, OVERTEMPERATURE_FLAG;
	logic BRIDGE_OVERCURRENT_DET, HIGH_SIDE_OVERCURRENT_DET, STANDBY;
	logic BRIDGE_OVERCURRENT_FLAG, HIGH_SIDE_OVERCURRENT_FLAG;
	logic [3:0] BUS_DATA_NIBBLE_IN, BUS_DATA_NIBBLE_OUT, BUS_DATA_NIBBLE_OE_N;
	logic [4:0] OUT_LEVEL_HIGH, OUT_LEVEL_LOW;
	bridge_cmd_pkg::drive_e BRIDGE1, BRIDGE2, BRIDGE3, BRIDGE4;
	bridge_cmd_pkg::drive_e HIGH_SIDE_OUTPUT;
	wire logic [14:0] drv = {BRIDGE1, BRIDGE2, BRIDGE3, BRIDGE4,
		HIGH_SIDE_OUTPUT};
	int err_count = 0;
	int total_checks = 0;

	bus_cmd_bridge #(.CLR_CYCLES(CLR)) dut (.*);
	bus_master_model master (.*);

	// Clock.
	initial begin
		MCLK = 1'h0;
		forever #20 MCLK = ~MCLK;
	end

	// =====
	// Shared tasks.
	task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Deselect for one step, so the next select is a falling edge.
	task automatic ds;
		master.put(1'h1, 1'h0, 1'h0, 4'h0);
	endtask
	// Change the nibble while selected; the drives must follow at once.
	task automatic wc(logic m, logic [3:0] d, logic [14:0] e);
		master.put(1'h0, 1'h0, m, d);
		#5;
		chk("drives", drv, e);
	endtask
	task automatic rd(logic m, logic [15:0] e);
		ds();
		repeat (2) @(negedge MCLK);
		master.put(1'h0, 1'h1, m, 4'h0);
		@(negedge MCLK);
		chk("read", BUS_DATA_NIBBLE_OUT, e);
		chk("read enable", BUS_DATA_NIBBLE_OE_N, 16'h0);
	endtask

	// =====
	// Scenarios.
	task automatic t_writes;
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_M1_RIGHT, {S, T, T, K, T});
		wc(1'h0, bridge_cmd_pkg::CMD_M1_LEFT, {K, T, T, S, T});
		wc(1'h0, bridge_cmd_pkg::CMD_M2_RIGHT, {T, S, T, K, T});
		wc(1'h0, bridge_cmd_pkg::CMD_M2_LEFT, {T, K, T, S, T});
		wc(1'h0, bridge_cmd_pkg::CMD_M3_RIGHT, {T, T, S, K, T});
		wc(1'h0, bridge_cmd_pkg::CMD_M3_LEFT, {T, T, K, S, T});
		wc(1'h0, bridge_cmd_pkg::CMD_BRAKE, {K, K, K, K, T});
		wc(1'h0, bridge_cmd_pkg::CMD_STANDBY, {5{T}});
		@(negedge MCLK);
		chk("standby", STANDBY, 16'h1);
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_HIGHSIDE, {T, T, T, T, S});
		wc(1'h1, 4'ha, {T, T, T, S4, T});
		wc(1'h1, 4'h1, {T, T, T, K4, T});
		wc(1'h1, 4'h6, {K1, K1, K1, S4, S1});
		wc(1'h0, bridge_cmd_pkg::CMD_CLEAR, {5{T}});
		wc(1'h0, bridge_cmd_pkg::CMD_M2_RIGHT, {T, S, T, K, T});
		ds();
		master.put(1'h1, 1'h1, 1'h1, 4'h9);
		repeat (3) @(negedge MCLK);
		chk("held drives", drv, {T, S, T, K, T});
		chk("bus free", BUS_DATA_NIBBLE_OE_N, 16'hf);
	endtask
	task automatic t_read;
		OUT_LEVEL_HIGH = 5'h15;
		OUT_LEVEL_LOW = 5'h0a;
		rd(1'h0, 16'h5);
		OUT_LEVEL_HIGH = 5'h0a;
		OUT_LEVEL_LOW = 5'h15;
		OVERTEMPERATURE_FLAG = 1'h1;
		rd(1'h0, 16'ha);
		rd(1'h1, 16'h4);
		OVERVOLTAGE_FLAG = 1'h1;
		rd(1'h1, 16'h7);
		OVERVOLTAGE_FLAG = 1'h0;
		OVERTEMPERATURE_FLAG = 1'h0;
	endtask
	task automatic t_ovc;
		BRIDGE_OVERCURRENT_DET = 1'h1;
		@(negedge MCLK);
		BRIDGE_OVERCURRENT_DET = 1'h0;
		rd(1'h1, {14'h0, bridge_cmd_pkg::FLT_BRIDGE});
		chk("bridge flag", BRIDGE_OVERCURRENT_FLAG, 16'h1);
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_M1_RIGHT, {S, T, T, K, T});
		@(negedge MCLK);
		chk("bridge flag", BRIDGE_OVERCURRENT_FLAG, 16'h0);
		// Raise the fault while deselected: a held write would clear it.
		ds();
		OUT_LEVEL_HIGH = 5'h10;
		OUT_LEVEL_LOW = 5'h00;
		HIGH_SIDE_OVERCURRENT_DET = 1'h1;
		@(negedge MCLK);
		HIGH_SIDE_OVERCURRENT_DET = 1'h0;
		rd(1'h1, {12'h0, 2'h2, bridge_cmd_pkg::FLT_HIGH});
		chk("high flag", HIGH_SIDE_OVERCURRENT_FLAG, 16'h1);
	endtask
	task automatic t_timeout;
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_M3_RIGHT, {T, T, S, K, T});
		repeat (CLR + 4) @(negedge MCLK);
		chk("clear", {STANDBY, drv}, {1'h1, {5{T}}});
		wc(1'h0, bridge_cmd_pkg::CMD_M1_LEFT, {5{T}});
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_M2_LEFT, {T, K, T, S, T});
	endtask
	task automatic t_reset_low;
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_BRAKE, {K, K, K, K, T});
		@(negedge MCLK);
		RESET_N = 1'h0;
		#5;
		chk("reset drives", drv, {5{T}});
		repeat (2) @(negedge MCLK);
		RESET_N = 1'h1;
		repeat (2) @(negedge MCLK);
		chk("low at power", {STANDBY, drv}, {1'h1, {5{T}}});
		wc(1'h0, bridge_cmd_pkg::CMD_BRAKE, {5{T}});
		ds();
		wc(1'h0, bridge_cmd_pkg::CMD_BRAKE, {K, K, K, K, T});
	endtask

	// Main sequence, reset held for twelve cycles with select high.
	initial begin
		RESET_N = 1'h0;
		OUT_LEVEL_HIGH = 5'h00;
		OUT_LEVEL_LOW = 5'h1f;
		BRIDGE_OVERCURRENT_DET = 1'h0;
		HIGH_SIDE_OVERCURRENT_DET = 1'h0;
		OVERVOLTAGE_FLAG = 1'h0;
		OVERTEMPERATURE_FLAG = 1'h0;
		repeat (12) @(negedge MCLK);
		RESET_N = 1'h1;
		@(negedge MCLK);
		chk("power standby", {STANDBY, drv}, {1'h1, {5{T}}});
		t_writes();
		t_read();
		t_ovc();
		t_timeout();
		t_reset_low();
		end_sim();
	end

	// Watchdog; the run needs under 120 cycles, so this is generous.
	initial begin
		repeat (2000) @(posedge MCLK);
		err_count++;
		end_sim();
	end
endmodule // parallel_bus_bridge_command_decoder_test

bind bus_cmd_bridge bus_cmd_bridge_chk #(.CLR_CYCLES(CLR_CYCLES)) u_chk (.*);
